// ==== core/qpc_pkg.sv ====
// Purpose: Shared constants for the quadrature position counter.
// Assumes: AXI4-Lite register window with 32-bit aligned words.
// Notes: Registers hold 16 bits in the low half; upper bits read as zero.
package qpc_pkg;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FILT = 8'h04;
  localparam logic [7:0] OFS_POS = 8'h08;
  localparam logic [7:0] OFS_MAX = 8'h0C;
  // ********************************
  // Field positions
  // ********************************
  localparam int CTRL_ERR_BIT = 15;
  localparam int CTRL_DIR_BIT = 11;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_POSITION_RESET_ENABLE_BIT = 2;
  localparam int FILT_COUNT_ERROR_IRQ_DISABLE_BIT = 8;
  localparam int FILT_IMV_LSB = 9;
  // ********************************
  // Counter modes and values
  // ********************************
  localparam logic [2:0] MODE_X2_IDX = 3'h4;
  localparam logic [2:0] MODE_X2_MAX = 3'h5;
  localparam logic [2:0] MODE_X4_IDX = 3'h6;
  localparam logic [2:0] MODE_X4_MAX = 3'h7;
  localparam logic [15:0] POS_RST = 16'h0000;
  localparam logic [15:0] MAX_RST = 16'hFFFF;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : qpc_pkg

// ==== core/qpc_dec_if.sv ====
// Purpose: Carries decoded encoder events from decoder to counter core.
// Assumes: Both ends run on the same clock.
// Notes: All decoder outputs are registered.
`timescale 1ns/1ps
interface qpc_dec_if;
  logic x4_mode;
  logic count_pulse;
  logic count_direction;
  logic phase_a;
  logic phase_b;
  logic index_rise;
  modport dec (
    input x4_mode,
    output count_pulse,
    output count_direction,
    output phase_a,
    output phase_b,
    output index_rise
  );
  modport core (
    output x4_mode,
    input count_pulse,
    input count_direction,
    input phase_a,
    input phase_b,
    input index_rise
  );
endinterface : qpc_dec_if

// ==== core/qpc_sync.sv ====
// Purpose: Two-stage synchroniser for asynchronous encoder pins.
// Assumes: Pins change slower than the clock.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module qpc_sync #(
  parameter int W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qpc_sync_t;

  qpc_sync_t st_r;
  qpc_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
      ($past(aresetn) && $past(aresetn, 2)) |-> dout == $past(din, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser delay is not two cycles");
endmodule : qpc_sync

// ==== core/qpc_decode.sv ====
// Purpose: Quadrature decoder producing count pulses and direction.
// Assumes: Inputs already synchronised to aclk.
// Notes: 2x mode counts phase A edges only; double changes are dropped.
`timescale 1ns/1ps
module qpc_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] sync_in,
  qpc_dec_if.dec dec
);
  typedef struct packed {
    logic a_p;
    logic b_p;
    logic i_p;
    logic pulse;
    logic dir;
    logic idx_rise;
  } qpc_dec_t;

  qpc_dec_t st_r;
  qpc_dec_t st_nxt;
  logic a_chg;
  logic b_chg;

  always_comb begin
    st_nxt = st_r;
    a_chg = sync_in[0] ^ st_r.a_p;
    b_chg = sync_in[1] ^ st_r.b_p;
    st_nxt.a_p = sync_in[0];
    st_nxt.b_p = sync_in[1];
    st_nxt.i_p = sync_in[2];
    st_nxt.idx_rise = sync_in[2] & ~st_r.i_p;
    // Both phases moving at once is ambiguous, so it is not counted
    if (dec.x4_mode) begin
      st_nxt.pulse = a_chg ^ b_chg;
    end else begin
      st_nxt.pulse = a_chg & ~b_chg;
    end
    // A leading B gives forward
    if (st_nxt.pulse) begin
      st_nxt.dir = sync_in[0] ^ st_r.b_p;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dec.count_pulse = st_r.pulse;
  assign dec.count_direction = st_r.dir;
  assign dec.phase_a = st_r.a_p;
  assign dec.phase_b = st_r.b_p;
  assign dec.index_rise = st_r.idx_rise;
endmodule : qpc_decode

// ==== core/qpc_top.sv ====
// Purpose: Quadrature position counter with AXI4-Lite registers.
// Assumes: Encoder pins asynchronous to aclk (25 MHz).
// Notes: One write and one read transaction in flight at a time.
// How it works
// - Phase A leading phase B means forward; lagging means reverse.
// - 16-bit position counts up or down per pulse by direction.
// - Error checking only in index-reset modes 110 and 100.
// - Count hitting 0xFFFF or max plus one sets error, raises interrupt.
// - Error flag is bit 15 of encoder control register.
// - Filter control bit 8 set suppresses count error interrupt.
// - After an error, counting continues until natural wrap.
// - Rollover or underflow at max in modes 101/111 raises no interrupt.
// - Error flag read/write; only software clears it.
// - Position reset enable is control bit 2, used in modes 100/110.
// - Enabled, a qualified index clears position; disabled, it does not.
// - Index reset needs phase levels matching filter bits 10:9.
// - In 4x, upper match bit is phase B level, lower phase A.
// - In 2x, upper bit picks phase, lower bit its level.
// - Index-reset modes raise the index interrupt on index detection.
// - Direction drives a pin and read-only control bit 11.
`timescale 1ns/1ps
module qpc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic index_in,
  output logic count_direction,
  output logic count_error_irq,
  output logic index_irq
);
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] max;
    logic err;
    logic [2:0] mode;
    logic position_reset_enable;
    logic count_error_irq_disable;
    logic [1:0] index_match_value;
    logic dir;
    logic err_irq;
    logic idx_irq;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qpc_state_t;

  qpc_state_t st_r;
  qpc_state_t st_nxt;
  logic [2:0] sync_q;
  logic checked;
  logic step;
  logic [15:0] pos_step;
  logic idx_ok;
  logic err_hit;
  logic ctrl_wr;
  logic pos_wr;
  logic plain_step;
  logic [15:0] wr_val;

  qpc_dec_if dec_if ();

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : merge16

  function automatic logic [15:0] ctrl_word(input qpc_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[qpc_pkg::CTRL_ERR_BIT] = s.err;
    v[qpc_pkg::CTRL_DIR_BIT] = s.dir;
    v[qpc_pkg::CTRL_MODE_LSB +: 3] = s.mode;
    v[qpc_pkg::CTRL_POSITION_RESET_ENABLE_BIT] = s.position_reset_enable;
    return v;
  endfunction : ctrl_word

  function automatic logic [15:0] filt_word(input qpc_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[qpc_pkg::FILT_COUNT_ERROR_IRQ_DISABLE_BIT] = s.count_error_irq_disable;
    v[qpc_pkg::FILT_IMV_LSB +: 2] = s.index_match_value;
    return v;
  endfunction : filt_word

  // Index qualifier on phase levels
  function automatic logic idx_match(
    input logic x4,
    input logic [1:0] index_match_value,
    input logic a,
    input logic b
  );
    logic sel;
    sel = index_match_value[1] ? b : a;
    if (x4) begin
      return (b == index_match_value[1]) && (a == index_match_value[0]);
    end
    return sel == index_match_value[0];
  endfunction : idx_match

  function automatic logic [31:0] read_word(
    input qpc_state_t s,
    input logic [7:0] addr
  );
    case (addr)
      qpc_pkg::OFS_CTRL: return {16'h0000, ctrl_word(s)};
      qpc_pkg::OFS_FILT: return {16'h0000, filt_word(s)};
      qpc_pkg::OFS_POS: return {16'h0000, s.pos};
      qpc_pkg::OFS_MAX: return {16'h0000, s.max};
      default: return 32'h00000000;
    endcase
  endfunction : read_word

  function automatic logic mapped(input logic [7:0] addr);
    return addr == qpc_pkg::OFS_CTRL || addr == qpc_pkg::OFS_FILT ||
           addr == qpc_pkg::OFS_POS || addr == qpc_pkg::OFS_MAX;
  endfunction : mapped

  // ********************************
  // Pin synchronisation and decoding
  // ********************************
  qpc_sync #(
    .W(3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({index_in, phase_b_in, phase_a_in}),
    .dout(sync_q)
  );

  qpc_decode u_decode (
    .aclk(aclk),
    .aresetn(aresetn),
    .sync_in(sync_q),
    .dec(dec_if.dec)
  );

  assign dec_if.x4_mode = st_r.mode[1];

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    st_nxt = st_r;
    ctrl_wr = 1'b0;
    pos_wr = 1'b0;
    wr_val = 16'h0000;
    st_nxt.err_irq = 1'b0;
    st_nxt.idx_irq = 1'b0;
    st_nxt.dir = dec_if.count_direction;
    checked = (st_r.mode == qpc_pkg::MODE_X4_IDX) ||
              (st_r.mode == qpc_pkg::MODE_X2_IDX);
    step = dec_if.count_pulse && st_r.mode[2];
    pos_step = dec_if.count_direction ? st_r.pos + qpc_pkg::CNT_ONE
                                      : st_r.pos - qpc_pkg::CNT_ONE;
    idx_ok = checked && dec_if.index_rise &&
             idx_match(st_r.mode[1], st_r.index_match_value, dec_if.phase_a,
                       dec_if.phase_b);
    // Error watch only; the counter itself is not stopped
    err_hit = checked && step &&
              (dec_if.count_direction ?
                 pos_step == st_r.max + qpc_pkg::CNT_ONE :
                 pos_step == qpc_pkg::CNT_ALL_ONES);
    if (step) begin
      if (!checked && dec_if.count_direction && st_r.pos == st_r.max) begin
        st_nxt.pos = qpc_pkg::POS_RST;
      end else if (!checked && !dec_if.count_direction &&
                   st_r.pos == qpc_pkg::POS_RST) begin
        st_nxt.pos = st_r.max;
      end else begin
        st_nxt.pos = pos_step;
      end
    end
    if (idx_ok) begin
      st_nxt.idx_irq = 1'b1;
      if (st_r.position_reset_enable) begin
        st_nxt.pos = qpc_pkg::POS_RST;
      end
    end
    // AXI write channels accepted independently
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(st_r.awaddr) ? qpc_pkg::RESP_OKAY
                                         : qpc_pkg::RESP_SLVERR;
      case (st_r.awaddr)
        qpc_pkg::OFS_CTRL: begin
          ctrl_wr = 1'b1;
          wr_val = merge16(ctrl_word(st_r), st_r.wdata, st_r.wstrb);
          st_nxt.err = wr_val[qpc_pkg::CTRL_ERR_BIT];
          st_nxt.mode = wr_val[qpc_pkg::CTRL_MODE_LSB +: 3];
          st_nxt.position_reset_enable = wr_val[qpc_pkg::CTRL_POSITION_RESET_ENABLE_BIT];
        end
        qpc_pkg::OFS_FILT: begin
          wr_val = merge16(filt_word(st_r), st_r.wdata, st_r.wstrb);
          st_nxt.count_error_irq_disable = wr_val[qpc_pkg::FILT_COUNT_ERROR_IRQ_DISABLE_BIT];
          st_nxt.index_match_value = wr_val[qpc_pkg::FILT_IMV_LSB +: 2];
        end
        qpc_pkg::OFS_POS: begin
          // Software load overrides a same-cycle count
          pos_wr = 1'b1;
          st_nxt.pos = merge16(st_r.pos, st_r.wdata, st_r.wstrb);
        end
        qpc_pkg::OFS_MAX: begin
          st_nxt.max = merge16(st_r.max, st_r.wdata, st_r.wstrb);
        end
        default: begin
          wr_val = 16'h0000;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    if (err_hit) begin
      st_nxt.err = 1'b1;
      st_nxt.err_irq = !st_r.count_error_irq_disable;
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    // AXI read
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = read_word(st_r, s_axi_araddr);
      st_nxt.rresp = mapped(s_axi_araddr) ? qpc_pkg::RESP_OKAY
                                          : qpc_pkg::RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    plain_step = step && checked && !(idx_ok && st_r.position_reset_enable) && !pos_wr;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.max <= qpc_pkg::MAX_RST;
      st_r.pos <= qpc_pkg::POS_RST;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign count_direction = st_r.dir;
  assign count_error_irq = st_r.err_irq;
  assign index_irq = st_r.idx_irq;

  // ********************************
  // Assertions
  // ********************************
  property p_fwd_dir;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(sync_q[0]) && !sync_q[1] && $stable(sync_q[1])) |->
        ##2 count_direction;
  endproperty
  a_fwd_dir: assert property (p_fwd_dir)
    else $error("A leading B did not give forward direction");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
      plain_step |=> st_r.pos == ($past(dec_if.count_direction) ?
        $past(st_r.pos) + qpc_pkg::CNT_ONE :
        $past(st_r.pos) - qpc_pkg::CNT_ONE);
  endproperty
  a_step: assert property (p_step)
    else $error("position did not move by one on a count pulse");

  property p_err_mode;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(st_r.err) && !$past(ctrl_wr)) |->
        ($past(st_r.mode) == qpc_pkg::MODE_X4_IDX ||
         $past(st_r.mode) == qpc_pkg::MODE_X2_IDX);
  endproperty
  a_err_mode: assert property (p_err_mode)
    else $error("count error flagged outside index modes");

  property p_err_set;
    @(posedge aclk) disable iff (!aresetn)
      err_hit |=> st_r.err;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("count error flag not set on limit match");

  property p_count_error_irq_disable;
    @(posedge aclk) disable iff (!aresetn)
      (err_hit && st_r.count_error_irq_disable) |=> !count_error_irq;
  endproperty
  a_count_error_irq_disable: assert property (p_count_error_irq_disable)
    else $error("count error interrupt not suppressed");

  property p_irq_src;
    @(posedge aclk) disable iff (!aresetn)
      count_error_irq |-> $past(err_hit) && !$past(st_r.count_error_irq_disable);
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("count error interrupt without a limit match");

  property p_err_hold;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.err && !ctrl_wr) |=> st_r.err;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("count error flag cleared by hardware");

  property p_idx_clear;
    @(posedge aclk) disable iff (!aresetn)
      (idx_ok && st_r.position_reset_enable && !pos_wr) |=> st_r.pos == qpc_pkg::POS_RST;
  endproperty
  a_idx_clear: assert property (p_idx_clear)
    else $error("qualified index did not clear the position");

  property p_idx_irq;
    @(posedge aclk) disable iff (!aresetn)
      index_irq |-> $past(idx_ok) && $past(checked);
  endproperty
  a_idx_irq: assert property (p_idx_irq)
    else $error("index interrupt without a qualified index");

  property p_dir_read;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == qpc_pkg::OFS_CTRL)
        |=> s_axi_rdata[qpc_pkg::CTRL_DIR_BIT] == $past(st_r.dir);
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("status direction bit does not match direction");
endmodule : qpc_top

// ==== tb/qpc_encoder_model.sv ====
// Purpose: Incremental encoder driving phase and index pins.
// Assumes: Pins change by non-blocking assignment after a rising edge.
// Notes: gap sets clocks between pin edges, so it can be prompt or slow.
`timescale 1ns/1ps
module qpc_encoder_model (
  input wire logic aclk,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  int st = 0;
  int gap = 4;
  initial begin
    phase_a <= 1'b0;
    phase_b <= 1'b0;
    index <= 1'b0;
  end
  // Forward order 00,10,11,01 puts A ahead of B
  task automatic move(input bit fwd);
    st = fwd ? (st + 1) % 4 : (st + 3) % 4;
    @(posedge aclk);
    phase_a <= (st == 1 || st == 2);
    phase_b <= (st >= 2);
    repeat (gap) @(posedge aclk);
  endtask : move
  // Index only while both phases sit low
  task automatic pulse_index();
    if (st == 0) begin
      @(posedge aclk);
      index <= 1'b1;
      repeat (gap) @(posedge aclk);
      index <= 1'b0;
      repeat (gap) @(posedge aclk);
    end
  endtask : pulse_index
endmodule : qpc_encoder_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the quadrature position counter.
// Assumes: Encoder model paces pins at three clocks or more.
// Notes: Integer model tracks count, flag, direction and interrupts.
`timescale 1ns/1ps
module testbench;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic pa, pb, ix, dir_pin, err_irq, idx_irq;
  int errors, n_tests, cycles, seen_err, seen_idx;
  int pos, maxc = 65535, mode, position_reset_enable, flag, dir, count_error_irq_disable, index_match_value, n_err, n_idx;
  logic [15:0] rnd = 16'h000D;
  localparam logic [1:0] OK = qpc_pkg::RESP_OKAY;
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  qpc_encoder_model i_enc (.aclk(aclk), .phase_a(pa), .phase_b(pb),
    .index(ix));
  qpc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .phase_a_in(pa), .phase_b_in(pb),
    .index_in(ix), .count_direction(dir_pin),
    .count_error_irq(err_irq), .index_irq(idx_irq));
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] ctrl_exp();
    return {16'h0, flag[0], 3'h0, dir[0], mode[2:0], 5'h0, position_reset_enable[0], 2'h0};
  endfunction : ctrl_exp
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check(rresp, er);
  endtask : rd
  task automatic set_cfg(input int m, input int pr, input int ce,
                         input int iv);
    mode = m;
    position_reset_enable = pr;
    count_error_irq_disable = ce;
    index_match_value = iv;
    flag = 0;
    wr(qpc_pkg::OFS_CTRL, ctrl_exp(), OK);
    wr(qpc_pkg::OFS_FILT, {21'h0, index_match_value[1:0], count_error_irq_disable[0], 8'h0}, OK);
    rd(qpc_pkg::OFS_FILT, {21'h0, index_match_value[1:0], count_error_irq_disable[0], 8'h0}, OK);
  endtask : set_cfg
  task automatic verify();
    rd(qpc_pkg::OFS_POS, pos, OK);
    if (mode[2]) begin
      check(dir_pin, dir);
      rd(qpc_pkg::OFS_CTRL, ctrl_exp(), OK);
    end
    check(seen_err, n_err);
    check(seen_idx, n_idx);
  endtask : verify
  // 2x counts only steps that move phase A
  task automatic step(input bit fwd);
    bit cnt;
    int nx;
    int lim;
    cnt = mode[2] && (mode[1] || ((i_enc.st % 2 == 0) == fwd));
    i_enc.move(fwd);
    if (cnt) begin
      dir = fwd;
      nx = (fwd ? pos + 1 : pos - 1) & 32'hFFFF;
      // Limit wraps with the 16-bit count
      lim = fwd ? (maxc + 1) & 32'hFFFF : 32'hFFFF;
      if (!mode[0]) begin
        if (nx == lim) begin
          flag = 1;
          if (count_error_irq_disable == 0) n_err++;
        end
        pos = nx;
      end else if (fwd) pos = (pos == maxc) ? 0 : pos + 1;
      else pos = (pos == 0) ? maxc : pos - 1;
    end
    verify();
  endtask : step
  // Phases are 00 at the index, so only the level bits decide
  task automatic do_index();
    bit hit;
    while (i_enc.st != 0) step(1'b1);
    hit = (mode == 6) ? (index_match_value == 0) : (index_match_value[0] == 0);
    i_enc.pulse_index();
    if (mode == 6 || mode == 4) begin
      if (hit) n_idx++;
      if (hit && position_reset_enable == 1) pos = 0;
    end
    verify();
  endtask : do_index
  always @(posedge aclk) begin
    cycles++;
    if (aresetn === 1'b1 && err_irq === 1'b1) seen_err++;
    if (aresetn === 1'b1 && idx_irq === 1'b1) seen_idx++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(qpc_pkg::OFS_CTRL, 32'h0, OK);
    rd(qpc_pkg::OFS_FILT, 32'h0, OK);
    rd(qpc_pkg::OFS_POS, 32'h0, OK);
    rd(qpc_pkg::OFS_MAX, 32'hFFFF, OK);
    rd(8'h10, 32'h0, qpc_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1234, qpc_pkg::RESP_SLVERR);
    step(1'b1);
    step(1'b1);
    // Random walks with wrap at a small maximum, slow and prompt pins
    for (int m = 7; m >= 5; m -= 2) begin
      rnd = lfsr(rnd);
      maxc = 3 + rnd[2:0];
      wr(qpc_pkg::OFS_MAX, maxc, OK);
      set_cfg(m, 0, 0, 0);
      for (int i = 0; i < 24; i++) begin
        rnd = lfsr(rnd);
        i_enc.gap = 3 + rnd[3:0];
        step(rnd[15]);
      end
    end
    // Errors both ways, interrupt allowed then suppressed
    i_enc.gap = 3;
    maxc = 2;
    wr(qpc_pkg::OFS_MAX, maxc, OK);
    for (int k = 0; k < 4; k++) begin
      set_cfg(k < 2 ? 6 : 4, 0, k % 2, 0);
      wr(qpc_pkg::OFS_POS, 32'h0, OK);
      pos = 0;
      repeat (8) step(1'b1);
      repeat (12) step(1'b0);
      set_cfg(mode, 0, 0, 0);
      rd(qpc_pkg::OFS_CTRL, ctrl_exp(), OK);
    end
    // Index match values in every reset mode, with and without clear
    maxc = 65535;
    wr(qpc_pkg::OFS_MAX, maxc, OK);
    for (int m = 4; m <= 7; m++) begin
      for (int k = 0; k < 8 && m != 5; k++) begin
        set_cfg(m, k / 4, 0, k % 4);
        rnd = lfsr(rnd);
        pos = {1'b0, rnd[14:0]};
        wr(qpc_pkg::OFS_POS, pos, OK);
        do_index();
      end
    end
    tally_and_finish();
  end
endmodule : testbench
